// *** hdl/sar_adc_cfg.svh ***
// Constants of the SAR converter control block
// Behaviour
// - Converter, track-and-hold and amplifier run only while the enable bit is 1.
// - Multiplexer offers eight external inputs plus an internal temperature channel.
// - Each input pair is single-ended or differential; all single-ended after reset.
// - Three-bit gain field selects 0.5 to 16; unity after reset.
// - SAR clock is the system clock divided by one more than the divider field.
// - Two-bit start mode picks software, timer 3, external edge or timer 2.
// - Busy reads 1 through a conversion and clears itself at completion.
// - Busy falling at completion sets the done flag and, if enabled, the interrupt request.
// - Result goes to high and low registers, justified by the justify bit.
// - With tracking mode 0 the input is tracked whenever idle.
// - With tracking mode 1 each software or timer start begins with three SAR clocks tracking.
// - Low-power mode with external start tracks while low, converts on rising edge.
// - Tracking is off while the chip is in standby or sleep.
// - Differential results are two's complement, single-ended results unsigned.
// - Gain code 000=1, 001=2, 010=4, 011=8, 10x=16, 11x=0.5.
// - Five-bit divider value equals system clock over SAR clock, minus one.
// - Four-bit channel address; any address 1xxx selects the temperature sensor.
`ifndef SAR_ADC_CFG_SVH
`define SAR_ADC_CFG_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CTRL   8'h00
`define OFS_CONFIG 8'h04
`define OFS_CHAN   8'h08
`define OFS_PAIR   8'h0c
`define OFS_RES_HI 8'h10
`define OFS_RES_LO 8'h14
`define OFS_IRQ_EN 8'h18
// ****************************************
// Field positions and reset values
// ****************************************
`define CTRL_EN    7
`define CTRL_TM    6
`define CTRL_DONE  5
`define CTRL_BUSY  4
`define CTRL_CM_HI 3
`define CTRL_CM_LO 2
`define CTRL_LJST  0
`define CFG_DIV_HI 7
`define CFG_DIV_LO 3
`define CFG_GAIN_HI 2
`define CFG_RST    8'hf8
`define CHAN_TEMP  3
`define RES_BITS   10
`define PAD_BITS   6
`define SAR_TOP    10'h200
`define TRACK_CLKS 2'h3
`endif

// *** hdl/sar_adc_pkg.sv ***
// Types shared by the SAR converter control block
`default_nettype none
package sar_adc_pkg;
    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_TRACK = 2'b01,
        S_CONV  = 2'b11
    } conv_state_t;
    typedef enum logic [1:0] {
        START_SW  = 2'b00,
        START_T3  = 2'b01,
        START_EXT = 2'b10,
        START_T2  = 2'b11
    } start_mode_t;
    typedef enum logic [2:0] {
        GAIN_1    = 3'h0,
        GAIN_2    = 3'h1,
        GAIN_4    = 3'h2,
        GAIN_8    = 3'h3,
        GAIN_16   = 3'h4,
        GAIN_HALF = 3'h5
    } gain_t;
endpackage
`default_nettype wire

// *** hdl/sar_adc_conversion_control.sv ***
// Control logic of a 10-bit SAR converter with a Wishbone register port
//
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "sar_adc_cfg.svh"
module sar_adc_conversion_control
    import sar_adc_pkg::*;
(
    input  wire logic        clk_i,          // System clock
    input  wire logic        rst_i,          // Synchronous reset
    input  wire logic        cyc_i,          // Wishbone cycle
    input  wire logic        stb_i,          // Wishbone strobe
    input  wire logic        we_i,           // Wishbone write
    input  wire logic [7:0]  adr_i,          // Byte address
    input  wire logic [3:0]  sel_i,          // Byte lanes
    input  wire logic [31:0] dat_i,          // Write data
    output logic      [31:0] dat_o,          // Read data
    output logic             ack_o,          // Wishbone ack
    input  wire logic        timer3_ovf_i,   // Timer 3 overflow pulse
    input  wire logic        timer2_ovf_i,   // Timer 2 overflow pulse
    input  wire logic        external_convert_start_i, // Start pin level
    input  wire logic        chip_standby_i, // Chip in standby or sleep
    input  wire logic        comp_i,         // Comparator: input above trial
    output logic             adc_power_o,    // Analog section powered
    output logic             track_o,        // Track-and-hold tracking
    output logic      [3:0]  mux_ch_o,       // Positive channel, 8 = temp
    output logic             diff_o,         // Differential pair selected
    output gain_t            gain_o,         // Decoded amplifier gain
    output logic      [9:0]  dac_code_o,     // SAR trial code
    output logic             conv_irq_o      // Conversion interrupt request
);
    // ****************************************
    // Registers
    // ****************************************
    logic        en_q, en_d, tm_q, tm_d, done_q, done_d, ljst_q, ljst_d;
    logic        ie_q, ie_d, ack_q, ack_d, cnv_q;
    start_mode_t cm_q, cm_d;
    logic [4:0]  div_q, div_d, dcnt_q, dcnt_d;
    logic [2:0]  gsel_q, gsel_d;
    logic [3:0]  chan_q, chan_d, pair_q, pair_d;
    logic [7:0]  rhi_q, rhi_d, rlo_q, rlo_d;
    logic [31:0] dat_d;
    conv_state_t st_q, st_d;
    logic [1:0]  tcnt_q, tcnt_d;
    logic [9:0]  sar_q, sar_d, msk_q, msk_d;
    logic        wr, sar_tick, ext_rise, start, sw_start, fin;
    logic [9:0]  res_raw, res_v;
    logic        sign;

    // ****************************************
    // Bus decode and start sources
    // ****************************************
    // Write lands on the edge where ack is seen by the master
    assign wr       = cyc_i && stb_i && we_i && ack_q && sel_i[0];
    assign ack_o    = ack_q;
    assign sar_tick = en_q && (dcnt_q == div_q);
    assign ext_rise = external_convert_start_i && !cnv_q;
    assign sw_start = wr && (adr_i == `OFS_CTRL) && dat_i[`CTRL_BUSY];
    // Trigger multiplexer, gated by enable
    always_comb begin
        unique case (cm_q)
            START_SW:  start = sw_start;
            START_T3:  start = timer3_ovf_i;
            START_EXT: start = ext_rise;
            START_T2:  start = timer2_ovf_i;
        endcase
        start = start && en_q && (st_q == S_IDLE);
    end

    // ****************************************
    // Conversion sequencer
    // ****************************************
    assign fin = (st_q == S_CONV) && sar_tick && msk_q[0];
    // Next state of sequencer, divider and SAR
    always_comb begin
        st_d   = st_q;
        tcnt_d = tcnt_q;
        sar_d  = sar_q;
        msk_d  = msk_q;
        dcnt_d = sar_tick ? 5'h0 : dcnt_q + 5'h1;
        if (start) begin
            // External start in low-power mode already tracked while low
            if (tm_q && cm_q != START_EXT) begin
                st_d = S_TRACK;
            end else begin
                st_d = S_CONV;
            end
            tcnt_d = 2'h0;
            sar_d  = `SAR_TOP;
            msk_d  = `SAR_TOP;
            dcnt_d = 5'h0;
        end
        unique case (st_q)
            S_IDLE: ;
            S_TRACK: begin
                if (sar_tick) begin
                    tcnt_d = tcnt_q + 2'h1;
                    if (tcnt_q == `TRACK_CLKS - 2'h1) begin
                        st_d = S_CONV;
                    end
                end
            end
            S_CONV: begin
                if (sar_tick) begin
                    // Keep the trial bit if input is above it, try the next
                    sar_d = (comp_i ? sar_q : (sar_q & ~msk_q)) | (msk_q >> 1);
                    msk_d = msk_q >> 1;
                    if (msk_q[0]) begin
                        st_d = S_IDLE;
                    end
                end
            end
            default: st_d = S_IDLE;
        endcase
        if (!en_q) begin
            st_d   = S_IDLE;
            dcnt_d = 5'h0;
        end
    end

    // ****************************************
    // Result formatting
    // ****************************************
    // Final bit decided in the same tick as completion
    assign res_raw = comp_i ? sar_q : (sar_q & ~msk_q);
    // Offset binary to two's complement by flipping the top bit
    assign res_v = diff_o ? {~res_raw[9], res_raw[8:0]} : res_raw;
    assign sign  = diff_o && res_v[9];

    // ****************************************
    // Register file next values
    // ****************************************
    always_comb begin
        en_d   = en_q;
        tm_d   = tm_q;
        cm_d   = cm_q;
        ljst_d = ljst_q;
        div_d  = div_q;
        gsel_d = gsel_q;
        chan_d = chan_q;
        pair_d = pair_q;
        ie_d   = ie_q;
        done_d = done_q;
        rhi_d  = rhi_q;
        rlo_d  = rlo_q;
        ack_d  = cyc_i && stb_i && !ack_q;
        dat_d  = 32'h0;
        if (wr) begin
            unique case (adr_i)
                `OFS_CTRL: begin
                    en_d   = dat_i[`CTRL_EN];
                    tm_d   = dat_i[`CTRL_TM];
                    done_d = dat_i[`CTRL_DONE];
                    cm_d   = start_mode_t'(dat_i[`CTRL_CM_HI:`CTRL_CM_LO]);
                    ljst_d = dat_i[`CTRL_LJST];
                end
                `OFS_CONFIG: begin
                    div_d  = dat_i[`CFG_DIV_HI:`CFG_DIV_LO];
                    gsel_d = dat_i[`CFG_GAIN_HI:0];
                end
                `OFS_CHAN:   chan_d = dat_i[3:0];
                `OFS_PAIR:   pair_d = dat_i[3:0];
                `OFS_IRQ_EN: ie_d   = dat_i[0];
                default: ;
            endcase
        end
        if (fin) begin
            done_d = 1'b1; // set wins over a clear
            if (ljst_q) begin
                {rhi_d, rlo_d} = {res_v, {`PAD_BITS{1'b0}}};
            end else begin
                {rhi_d, rlo_d} = {{`PAD_BITS{sign}}, res_v};
            end
        end
        // Read data prepared as ack rises
        if (cyc_i && stb_i && !we_i && !ack_q) begin
            unique case (adr_i)
                `OFS_CTRL: dat_d[7:0] = {en_q, tm_q, done_q, st_q != S_IDLE,
                                         cm_q, 1'b0, ljst_q};
                `OFS_CONFIG: dat_d[7:0] = {div_q, gsel_q};
                `OFS_CHAN:   dat_d[3:0] = chan_q;
                `OFS_PAIR:   dat_d[3:0] = pair_q;
                `OFS_RES_HI: dat_d[7:0] = rhi_q;
                `OFS_RES_LO: dat_d[7:0] = rlo_q;
                `OFS_IRQ_EN: dat_d[0]   = ie_q;
                default: ;
            endcase
        end
    end

    // Registering of every state group
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_q   <= 1'b0;
            tm_q   <= 1'b0;
            cm_q   <= START_SW;
            ljst_q <= 1'b0;
            {div_q, gsel_q} <= `CFG_RST;
            chan_q <= 4'h0;
            pair_q <= 4'h0;
            ie_q   <= 1'b0;
            done_q <= 1'b0;
            rhi_q  <= 8'h0;
            rlo_q  <= 8'h0;
            ack_q  <= 1'b0;
            dat_o  <= 32'h0;
            st_q   <= S_IDLE;
            tcnt_q <= 2'h0;
            sar_q  <= 10'h0;
            msk_q  <= 10'h0;
            dcnt_q <= 5'h0;
            cnv_q  <= 1'b0;
        end else begin
            en_q   <= en_d;
            tm_q   <= tm_d;
            cm_q   <= cm_d;
            ljst_q <= ljst_d;
            div_q  <= div_d;
            gsel_q <= gsel_d;
            chan_q <= chan_d;
            pair_q <= pair_d;
            ie_q   <= ie_d;
            done_q <= done_d;
            rhi_q  <= rhi_d;
            rlo_q  <= rlo_d;
            ack_q  <= ack_d;
            dat_o  <= dat_d;
            st_q   <= st_d;
            tcnt_q <= tcnt_d;
            sar_q  <= sar_d;
            msk_q  <= msk_d;
            dcnt_q <= dcnt_d;
            cnv_q  <= external_convert_start_i;
        end
    end

    // ****************************************
    // Analog side controls
    // ****************************************
    assign adc_power_o = en_q;
    assign dac_code_o  = sar_q;
    assign conv_irq_o  = done_q && ie_q;
    // Top address bit overrides pair setting for the temperature sensor
    assign diff_o   = !chan_q[`CHAN_TEMP] && pair_q[chan_q[2:1]];
    assign mux_ch_o = chan_q[`CHAN_TEMP] ? 4'h8 :
                      (diff_o ? {1'b0, chan_q[2:1], 1'b0} : chan_q);
    // Tracking choice; standby stops it to save power
    always_comb begin
        track_o = 1'b0;
        if (en_q && !chip_standby_i) begin
            if (st_q == S_TRACK) begin
                track_o = 1'b1;
            end else if (st_q == S_IDLE) begin
                if (!tm_q) begin
                    track_o = 1'b1;
                end else if (cm_q == START_EXT) begin
                    track_o = !external_convert_start_i;
                end
            end
        end
    end
    // Gain code decode
    always_comb begin
        unique casez (gsel_q)
            3'b000:  gain_o = GAIN_1;
            3'b001:  gain_o = GAIN_2;
            3'b010:  gain_o = GAIN_4;
            3'b011:  gain_o = GAIN_8;
            3'b10?:  gain_o = GAIN_16;
            default: gain_o = GAIN_HALF;
        endcase
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    off_idle_a: assert property (!en_q |=> st_q == S_IDLE)
        else $error("sequencer active while disabled");
    done_set_a: assert property ($fell(st_q != S_IDLE) && $past(en_q) |-> done_q)
        else $error("done flag not set at completion");
    irq_out_a: assert property (fin && ie_d |=> conv_irq_o)
        else $error("interrupt not raised at completion");
    track_idle_a: assert property (en_q && !tm_q && st_q == S_IDLE && !chip_standby_i |-> track_o)
        else $error("not tracking while idle");
    lp_track_a: assert property (start && tm_q && cm_q != START_EXT |=>
        st_q == S_TRACK && (track_o || chip_standby_i || !en_q))
        else $error("low-power start skipped tracking");
    ext_lp_a: assert property (tm_q && cm_q == START_EXT && st_q == S_IDLE &&
        external_convert_start_i |-> !track_o)
        else $error("tracking while start pin high");
    standby_off_a: assert property (chip_standby_i |-> !track_o)
        else $error("tracking during standby");
    temp_sel_a: assert property (chan_q[`CHAN_TEMP] |-> mux_ch_o == 4'h8 && !diff_o)
        else $error("temperature channel not selected");
    left_pad_a: assert property (fin && ljst_q |=> rlo_q[5:0] == 6'h0)
        else $error("left-justified low bits not zero");
    div_tick_a: assert property (en_q && $past(en_q) && sar_tick |->
        $past(dcnt_q) == div_q - 5'h1 || $past(sar_tick) || $past(start))
        else $error("divider tick off count");
    reset_dflt_a: assert property ($past(rst_i) |-> pair_q == 4'h0 && gain_o == GAIN_1)
        else $error("reset defaults wrong");
endmodule
`default_nettype wire

// *** bench/sar_adc_partner.sv ***
// Model of the timers, convert-start pin and analog input around the converter
`timescale 1ns/10ps
`default_nettype none
module sar_adc_partner (
    input  wire logic       clk_i,      // System clock
    input  wire logic       fire3_i,    // Request a timer 3 overflow
    input  wire logic       fire2_i,    // Request a timer 2 overflow
    input  wire logic       ext_lvl_i,  // Wanted convert-start level
    input  wire logic [9:0] vin_i,      // Analog input as ideal code
    input  wire logic [9:0] dac_i,      // Trial code from converter
    output logic            t3_o,       // Timer 3 overflow pulse
    output logic            t2_o,       // Timer 2 overflow pulse
    output logic            ext_o,      // Convert-start pin
    output logic            comp_o      // Comparator result
);
    // ****************************************
    // Timers and pin
    // ****************************************
    // Registered so each output follows its request one cycle later
    always_ff @(posedge clk_i) begin
        t3_o  <= fire3_i;
        t2_o  <= fire2_i;
        ext_o <= ext_lvl_i;
    end
    // Ideal comparator, no offset or noise
    assign comp_o = (vin_i >= dac_i);
endmodule
`default_nettype wire

// *** bench/sar_adc_conversion_control_bench.sv ***
// Self-checking testbench of the SAR converter control block
`timescale 1ns/10ps
`default_nettype none
module sar_adc_conversion_control_bench;
    import sar_adc_pkg::*;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
    logic        fire3, fire2, ext_lvl, chip_standby_i, comp_i;
    logic        timer3_ovf_i, timer2_ovf_i, external_convert_start_i;
    logic        adc_power_o, track_o, diff_o, conv_irq_o;
    logic [7:0]  adr_i, q;
    logic [3:0]  sel_i, mux_ch_o;
    logic [31:0] dat_i, dat_o;
    logic [9:0]  vin, dac_code_o;
    gain_t       gain_o;
    logic [15:0] r;
    int          n_fail = 0;
    int          n_compared = 0;
    int          n0, n1;
    localparam logic [7:0]  CT [8] = '{8'h80, 8'h81, 8'h84, 8'h88, 8'h8c, 8'h80, 8'h81, 8'h80};
    localparam logic [1:0]  TR [8] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h0};
    localparam logic [9:0]  VI [8] = '{10'h2a5, 10'h2a5, 10'h3ff, 10'h001, 10'h000, 10'h100, 10'h100, 10'h2ff};
    localparam logic [7:0]  PR [8] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h1, 8'h1, 8'h1};
    localparam logic [15:0] EX [8] = '{16'h02a5, 16'ha940, 16'h03ff, 16'h0001, 16'h0000, 16'hff00, 16'hc000, 16'h00ff};

    sar_adc_conversion_control i_sar_adc_conversion_control (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
        .sel_i, .dat_i, .dat_o, .ack_o, .timer3_ovf_i, .timer2_ovf_i, .external_convert_start_i,
        .chip_standby_i, .comp_i, .adc_power_o, .track_o, .mux_ch_o, .diff_o, .gain_o, .dac_code_o, .conv_irq_o);
    sar_adc_partner i_sar_adc_partner (.clk_i(clk_i), .fire3_i(fire3), .fire2_i(fire2), .ext_lvl_i(ext_lvl),
        .vin_i(vin), .dac_i(dac_code_o), .t3_o(timer3_ovf_i), .t2_o(timer2_ovf_i),
        .ext_o(external_convert_start_i), .comp_o(comp_i));

    // ****************************************
    // Clock and helpers
    // ****************************************
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic summarize();
        if (n_fail == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One classic cycle; returns one edge after ack so written state has settled
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        q = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
        if (n >= 50) begin
            n_fail++;
            summarize();
        end
    endtask
    task automatic pulse(input logic t3);
        @(posedge clk_i);
        if (t3) begin
            fire3 <= 1'b1;
        end else begin
            fire2 <= 1'b1;
        end
        @(posedge clk_i);
        fire3 <= 1'b0;
        fire2 <= 1'b0;
    endtask
    task automatic wait_irq(output int n);
        n = 0;
        while (conv_irq_o !== 1'b1 && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 2000) begin
            n_fail++;
            summarize();
        end
    endtask
    // Interrupt flow: clear done, trigger, wait for conv_irq_o, read both result bytes
    task automatic conv(input logic [7:0] ctl, input logic [1:0] trig, input logic [9:0] v, output int n);
        vin <= v;
        wb(1'b1, 8'h00, ctl);
        case (trig)
            2'h0: wb(1'b1, 8'h00, ctl | 8'h10);
            2'h1: pulse(1'b1);
            2'h2: ext_lvl <= 1'b1;
            default: pulse(1'b0);
        endcase
        wait_irq(n);
        ext_lvl <= 1'b0;
        wb(1'b0, 8'h10, 8'h00);
        r[15:8] = q;
        wb(1'b0, 8'h14, 8'h00);
        r[7:0] = q;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        {rst_i, sel_i} = 5'h1f;
        {cyc_i, stb_i, we_i, fire3, fire2, ext_lvl, chip_standby_i} = 7'h0;
        {adr_i, dat_i, vin} = 50'h0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 8'h04, 8'h00);
        chk(16'(q), 16'h00f8);
        chk(16'(gain_o), 16'(GAIN_1));
        wb(1'b0, 8'h0c, 8'h00);
        chk(16'(q), 16'h0000);
        wb(1'b0, 8'h1c, 8'h00);
        chk(16'(q), 16'h0000);                  // Unmapped place reads zero
        wb(1'b1, 8'h00, 8'h10);
        wb(1'b0, 8'h00, 8'h00);
        chk(16'({q, adc_power_o, track_o}), 16'h0000);
        wb(1'b1, 8'h18, 8'h01);
        wb(1'b1, 8'h00, 8'h80);
        chk(16'({adc_power_o, track_o}), 16'h0003);
        chip_standby_i <= 1'b1;
        @(posedge clk_i);
        chk(16'(track_o), 16'h0000);
        chip_standby_i <= 1'b0;
        // Slow default divider keeps busy visible over several accesses
        wb(1'b1, 8'h00, 8'h90);
        wb(1'b0, 8'h00, 8'h00);
        chk(16'(q), 16'h0090);
        wait_irq(n0);
        wb(1'b0, 8'h00, 8'h00);
        chk(16'({q, conv_irq_o}), 16'h0141);
        for (int k = 0; k < 8; k++) begin
            wb(1'b1, 8'h04, 8'(k));
            chk(16'(gain_o), (k < 4) ? 16'(k) : (k < 6) ? 16'h4 : 16'h5);
        end
        wb(1'b1, 8'h08, 8'h09);
        chk(16'({mux_ch_o, diff_o}), 16'h0010);
        wb(1'b1, 8'h0c, 8'h01);
        wb(1'b1, 8'h08, 8'h01);
        chk(16'({mux_ch_o, diff_o}), 16'h0001);
        wb(1'b1, 8'h08, 8'h00);
        // Wrong timer must not start a conversion
        wb(1'b1, 8'h00, 8'h84);
        pulse(1'b0);
        repeat (40) @(posedge clk_i);
        chk(16'(conv_irq_o), 16'h0000);
        pulse(1'b1);
        wait_irq(n0);
        for (int k = 0; k < 8; k++) begin
            wb(1'b1, 8'h0c, PR[k]);
            conv(CT[k], TR[k], VI[k], n0);
            chk(r, EX[k]);
        end
        wb(1'b1, 8'h0c, 8'h00);
        wb(1'b1, 8'h04, 8'h08);
        conv(8'h80, 2'h0, 10'h155, n0);
        conv(8'hc0, 2'h0, 10'h155, n1);
        chk(16'(n1 - n0), 16'h0006);
        conv(8'h88, 2'h2, 10'h155, n0);
        conv(8'hc8, 2'h2, 10'h155, n1);
        chk(16'(n1 - n0), 16'h0000);
        summarize();
    end
endmodule
`default_nettype wire
